//--- logic/pmd_top.sv
// processor mode decoder with status word, avalon slave and address former
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
module pmd_top #(
  parameter int AVS_ADDR_W = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic exceptionEnter,
  input wire logic errorEnter,
  input wire logic levelReturn,
  input pmd_pkg::pmd_addr_s effAddr,
  output pmd_pkg::pmd_mode_s modeOut,
  output pmd_pkg::pmd_maddr_s memAddr
);

  // the decode needs at least the three word offsets
  if (AVS_ADDR_W < 4) begin : g_bad_width
    $error("pmd_top: AVS_ADDR_W must be at least 4");
  end

  // state
  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [1:0] fault_q;
  logic [1:0] fault_d;
  logic waitReq_q;
  logic waitReq_d;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  logic [1:0] resp_q;
  logic [1:0] resp_d;
  pmd_pkg::pmd_mode_s mode_q;
  pmd_pkg::pmd_maddr_s mem_q;

  // combinational results of the two leaves
  pmd_pkg::pmd_mode_s modeNow;
  pmd_pkg::pmd_maddr_s memNow;

  pmd_mode_decode u_decode (
    .statusWord(status_q),
    .modeOut(modeNow)
  );

  pmd_addr_former u_former (
    .wideMode(modeNow.wide),
    .effIn(effAddr),
    .memOut(memNow)
  );

  // bus handshake: one wait cycle, then the access commits
  wire logic busReq = avs_read | avs_write;
  wire logic busSample = busReq & waitReq_q;
  wire logic busCommit = busReq & !waitReq_q;
  wire logic wrCommit = busCommit & avs_write;

  // address decode; upper address bits must be zero
  wire logic upperZero = (avs_address >> 4) == '0;
  wire logic [3:0] lowAddr = avs_address[3:0];
  wire logic hitStatus = upperZero && (lowAddr == pmd_pkg::OFF_STATUS);
  wire logic hitMode = upperZero && (lowAddr == pmd_pkg::OFF_MODE);
  wire logic hitFault = upperZero && (lowAddr == pmd_pkg::OFF_FAULT);
  wire logic hitAny = hitStatus | hitMode | hitFault;

  // byte lane mask built from the byte enables
  wire logic [31:0] laneMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // only kernel level may rewrite the status word
  wire logic isKernel = modeNow.level == pmd_pkg::LVL_KERNEL;
  wire logic wrStatusOk = wrCommit && hitStatus && isKernel;
  wire logic wrStatusBad = wrCommit && hitStatus && !isKernel;
  wire logic wrFault = wrCommit && hitFault;

  // merged write value, reserved bits kept zero
  wire logic [31:0] wrMerged = ((avs_writedata & laneMask) | (status_q & ~laneMask))
                               & pmd_pkg::STATUS_MASK;

  // level flag events from the core; return clears error first, else exception
  wire logic retErr = levelReturn && status_q[pmd_pkg::BIT_ERR];
  wire logic retExc = levelReturn && !status_q[pmd_pkg::BIT_ERR];

  // status next value: software write, then core events on top
  always_comb begin
    status_d = status_q;
    if (wrStatusOk) begin
      status_d = wrMerged;
    end
    if (retErr) begin
      status_d[pmd_pkg::BIT_ERR] = 1'b0;
    end
    if (retExc) begin
      status_d[pmd_pkg::BIT_EXC] = 1'b0;
    end
    // entering a level wins over any clear in the same cycle
    if (exceptionEnter) begin
      status_d[pmd_pkg::BIT_EXC] = 1'b1;
    end
    if (errorEnter) begin
      status_d[pmd_pkg::BIT_ERR] = 1'b1;
    end
  end

  // fault flags: write one to clear, a new event wins over the clear
  wire logic [1:0] faultClr = wrFault ? (avs_writedata[1:0] & {2{avs_byteenable[0]}}) : 2'h0;
  wire logic [1:0] faultSet = {memNow.err, wrStatusBad};

  always_comb begin
    fault_d = (fault_q & ~faultClr) | faultSet;
  end

  // mode readback word shows the decoded state
  wire logic [31:0] modeWord = {26'h0, mode_q.forced, mode_q.isa4, mode_q.isa3,
                                mode_q.wide, mode_q.level};
  wire logic [31:0] faultWord = {30'h0, fault_q};
  wire logic [31:0] rdMux = hitStatus ? status_q :
                            hitMode ? modeWord :
                            hitFault ? faultWord : 32'h0;

  // read data and response are captured while waitrequest is high
  always_comb begin
    waitReq_d = !busSample;
    rdData_d = rdData_q;
    resp_d = resp_q;
    if (busSample) begin
      rdData_d = avs_read ? rdMux : 32'h0;
      resp_d = hitAny ? pmd_pkg::RESP_OKAY : pmd_pkg::RESP_SLVERR;
    end
  end

  // register file and handshake flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= pmd_pkg::STATUS_RESET;
      fault_q <= 2'h0;
      waitReq_q <= 1'b1;
      rdData_q <= 32'h0;
      resp_q <= pmd_pkg::RESP_OKAY;
    end else begin
      status_q <= status_d;
      fault_q <= fault_d;
      waitReq_q <= waitReq_d;
      rdData_q <= rdData_d;
      resp_q <= resp_d;
    end
  end

  // decode results registered every cycle so outputs come from flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= '{forced: 1'b1, isa4: 1'b1, isa3: 1'b1, wide: 1'b0,
                  level: pmd_pkg::LVL_KERNEL};
      mem_q <= '0;
    end else begin
      mode_q <= modeNow;
      mem_q <= memNow;
    end
  end

  // port drive
  assign avs_readdata = rdData_q;
  assign avs_waitrequest = waitReq_q;
  assign avs_response = resp_q;
  assign modeOut = mode_q;
  assign memAddr = mem_q;

endmodule

//--- pkg/pmd_pkg.sv
// constants, types and register layout for the processor mode decoder
// What this block does
// - three levels kernel, supervisor, user; two widths
// - only kernel level may rewrite the status word
// - select field 10 user, 01 supervisor, 00 kernel
// - exception or error flag forces kernel level
// - mode bits sit at fixed status word positions
// - kernel-class levels: wide bit picks width, all sets
// - supervisor: wide bit gives 64-bit and third set
// - user: wide bit and fourth-set bit independent
// - address width follows decoded mode only
package pmd_pkg;

  // byte offsets on the register bus
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_MODE = 4'h4;
  localparam logic [3:0] OFF_FAULT = 4'h8;

  // status word field positions
  localparam int BIT_ISA4 = 31;
  localparam int BIT_KWIDE = 7;
  localparam int BIT_SWIDE = 6;
  localparam int BIT_UWIDE = 5;
  localparam int BIT_SEL_HI = 4;
  localparam int BIT_SEL_LO = 3;
  localparam int BIT_ERR = 2;
  localparam int BIT_EXC = 1;

  // implemented status bits; the rest read as zero
  localparam logic [31:0] STATUS_MASK = 32'h8000_00fe;
  // after reset the error flag holds the core at kernel level
  localparam logic [31:0] STATUS_RESET = 32'h0000_0004;

  // mode readback field positions
  localparam int MODE_LVL_LO = 0;
  localparam int MODE_WIDE = 2;
  localparam int MODE_ISA3 = 3;
  localparam int MODE_ISA4 = 4;
  localparam int MODE_FORCED = 5;

  // fault register bit positions
  localparam int FAULT_PRIV = 0;
  localparam int FAULT_ADDR = 1;

  // avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // privilege levels, highest first
  typedef enum logic [1:0] {
    LVL_KERNEL = 2'h0,
    LVL_SUPER = 2'h1,
    LVL_USER = 2'h2
  } pmd_level_e;

  // decoded mode bundle
  typedef struct packed {
    logic forced;
    logic isa4;
    logic isa3;
    logic wide;
    pmd_level_e level;
  } pmd_mode_s;

  // address request and answer
  typedef struct packed {
    logic valid;
    logic [63:0] addr;
  } pmd_addr_s;

  typedef struct packed {
    logic valid;
    logic err;
    logic [63:0] addr;
  } pmd_maddr_s;

endpackage

//--- logic/pmd_mode_decode.sv
// combinational decode of the status word into level, width and isa enables
module pmd_mode_decode (
  input wire logic [31:0] statusWord,
  output pmd_pkg::pmd_mode_s modeOut
);

  // field extraction at fixed positions
  wire logic isa4Bit = statusWord[pmd_pkg::BIT_ISA4];
  wire logic kWide = statusWord[pmd_pkg::BIT_KWIDE];
  wire logic sWide = statusWord[pmd_pkg::BIT_SWIDE];
  wire logic uWide = statusWord[pmd_pkg::BIT_UWIDE];
  wire logic [1:0] sel = statusWord[pmd_pkg::BIT_SEL_HI:pmd_pkg::BIT_SEL_LO];
  wire logic errFlag = statusWord[pmd_pkg::BIT_ERR];
  wire logic excFlag = statusWord[pmd_pkg::BIT_EXC];

  // either flag overrides the select field
  wire logic forced = errFlag | excFlag;
  wire logic isUser = !forced && (sel == 2'h2);
  wire logic isSuper = !forced && (sel == 2'h1);

  // code 11 is not a documented level; it is treated as kernel
  always_comb begin
    modeOut.forced = forced;
    if (isUser) begin
      modeOut.level = pmd_pkg::LVL_USER;
      modeOut.wide = uWide;
      modeOut.isa3 = uWide;
      modeOut.isa4 = isa4Bit;
    end else if (isSuper) begin
      modeOut.level = pmd_pkg::LVL_SUPER;
      modeOut.wide = sWide;
      modeOut.isa3 = sWide;
      modeOut.isa4 = 1'b1;
    end else begin
      modeOut.level = pmd_pkg::LVL_KERNEL;
      modeOut.wide = kWide;
      modeOut.isa3 = 1'b1;
      modeOut.isa4 = 1'b1;
    end
  end

endmodule

//--- logic/pmd_addr_former.sv
// forms a 32-bit or 64-bit memory address from the effective address
module pmd_addr_former (
  input wire logic wideMode,
  input pmd_pkg::pmd_addr_s effIn,
  output pmd_pkg::pmd_maddr_s memOut
);

  // in narrow mode the upper half must copy bit 31
  wire logic [31:0] upperSign = {32{effIn.addr[31]}};
  wire logic badNarrow = !wideMode && (effIn.addr[63:32] != upperSign);
  wire logic [63:0] narrowAddr = {upperSign, effIn.addr[31:0]};

  // width chosen only by the decoded mode
  assign memOut.valid = effIn.valid;
  assign memOut.addr = wideMode ? effIn.addr : narrowAddr;
  assign memOut.err = effIn.valid && badNarrow;

endmodule

//--- verification/pmd_asserts.sv
// port-level assertions for the processor mode decoder
module pmd_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic exceptionEnter,
  input wire logic errorEnter,
  input pmd_pkg::pmd_addr_s effAddr,
  input pmd_pkg::pmd_mode_s modeOut,
  input pmd_pkg::pmd_maddr_s memAddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // kernel-class levels keep every instruction set on
  chk_kernel_isa: assert property (modeOut.level == pmd_pkg::LVL_KERNEL |->
    modeOut.isa3 && modeOut.isa4) else $error("kernel isa disabled");
  chk_super_isa: assert property (modeOut.level == pmd_pkg::LVL_SUPER |->
    modeOut.isa4 && modeOut.isa3 == modeOut.wide) else $error("supervisor isa wrong");
  chk_user_isa3: assert property (modeOut.level == pmd_pkg::LVL_USER |->
    modeOut.isa3 == modeOut.wide) else $error("user isa3 not tied to width");
  chk_forced_kernel: assert property (modeOut.forced |->
    modeOut.level == pmd_pkg::LVL_KERNEL) else $error("forced level not kernel");
  chk_level_code: assert property (modeOut.level != 2'h3) else $error("bad level");
  // flags land one cycle after the event, the decode one cycle later
  chk_event_force: assert property ((exceptionEnter || errorEnter) |->
    ##2 modeOut.forced) else $error("flag event did not force kernel");
  chk_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing");
  chk_addr_low: assert property (effAddr.valid |=> memAddr.valid &&
    memAddr.addr[31:0] == $past(effAddr.addr[31:0])) else $error("address low half");
endmodule

bind pmd_top pmd_asserts pmd_asserts_i (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .exceptionEnter(exceptionEnter),
  .errorEnter(errorEnter), .effAddr(effAddr), .modeOut(modeOut), .memAddr(memAddr));

//--- verification/tb_pmd_top.sv
// self-checking bench for the processor mode decoder
module tb_pmd_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, rd = 0, wr = 0, exc = 0, err = 0, ret = 0, wreq;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, r;
  logic [1:0] resp, s;
  pmd_pkg::pmd_addr_s eff = '0;
  pmd_pkg::pmd_mode_s mode;
  pmd_pkg::pmd_maddr_s mem;
  int n_fail = 0, tests_run = 0, cyc = 0;
  logic [31:0] vals [7] = '{32'h0000_0010, 32'h8000_0010, 32'h0000_0030, 32'h8000_0030,
    32'h0000_0008, 32'h0000_0048, 32'h7fff_ff80};
  pmd_top pmd_top_i (.clk(clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .avs_response(resp), .exceptionEnter(exc), .errorEnter(err),
    .levelReturn(ret), .effAddr(eff), .modeOut(mode), .memAddr(mem));
  initial forever #2.5 clk = ~clk;
  // a hang anywhere ends the run here
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      summarize();
    end
  end
  // expected decode, worked out independently of the design
  function automatic pmd_pkg::pmd_mode_s expMode(input logic [31:0] v);
    pmd_pkg::pmd_mode_s m;
    m.forced = v[2] | v[1];
    if (m.forced || v[4:3] == 2'b00 || v[4:3] == 2'b11)
      m = '{m.forced, 1'b1, 1'b1, v[7], pmd_pkg::LVL_KERNEL};
    else if (v[4:3] == 2'b01)
      m = '{1'b0, 1'b1, v[6], v[6], pmd_pkg::LVL_SUPER};
    else
      m = '{1'b0, v[31], v[5], v[5], pmd_pkg::LVL_USER};
    return m;
  endfunction
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkMode(input logic [31:0] v);
    tests_run++;
    if (mode !== expMode(v)) begin
      n_fail++;
      $display("[FAIL] %0t mode %h for status %h", $time, mode, v);
    end
  endtask
  // one avalon access; held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    r = rdat;
    s = resp;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // one-cycle core event: 0 exception enter, 1 error enter, 2 level return
  task automatic pulse(input logic [1:0] which);
    case (which)
      2'h0: exc <= 1'b1;
      2'h1: err <= 1'b1;
      default: ret <= 1'b1;
    endcase
    @(posedge clk);
    exc <= 1'b0;
    err <= 1'b0;
    ret <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic testTable();
    foreach (vals[i]) begin
      pulse(2'h1);
      bus(1'b1, pmd_pkg::OFF_STATUS, vals[i]);
      bus(1'b0, pmd_pkg::OFF_STATUS, 32'h0);
      chk32(r, vals[i] & pmd_pkg::STATUS_MASK);
      chkMode(vals[i] & pmd_pkg::STATUS_MASK);
      bus(1'b0, pmd_pkg::OFF_MODE, 32'h0);
      chk32(r, {26'h0, expMode(vals[i] & pmd_pkg::STATUS_MASK)});
    end
    $display("table test done");
  endtask
  task automatic testUser();
    pulse(2'h1);
    bus(1'b1, pmd_pkg::OFF_STATUS, 32'h10);
    bus(1'b1, pmd_pkg::OFF_STATUS, 32'h0);
    chk32({30'h0, s}, {30'h0, pmd_pkg::RESP_OKAY});
    bus(1'b0, pmd_pkg::OFF_FAULT, 32'h0);
    chk32(r & 32'h1, 32'h1);
    eff <= '{1'b1, 64'h0000_0000_8000_0000};
    @(posedge clk);
    eff <= '0;
    @(posedge clk);
    chk32({31'h0, mem.err}, 32'h1);
    chk32(mem.addr[63:32], 32'hffff_ffff);
    // both fault bits are set now; writing ones clears them
    bus(1'b1, pmd_pkg::OFF_FAULT, 32'h3);
    bus(1'b0, pmd_pkg::OFF_FAULT, 32'h0);
    chk32(r, 32'h0);
    pulse(2'h0);
    chkMode(32'h12);
    pulse(2'h2);
    chkMode(32'h10);
    bus(1'b0, 4'hc, 32'h0);
    chk32({s, r[29:0]}, {pmd_pkg::RESP_SLVERR, 30'h0});
    $display("user test done");
  endtask
  // kernel level with the wide bit: a full 64-bit address passes untouched
  task automatic testWide();
    pulse(2'h1);
    bus(1'b1, pmd_pkg::OFF_STATUS, 32'h0000_0080);
    eff <= '{1'b1, 64'h0123_4567_89ab_cdef};
    @(posedge clk);
    eff <= '0;
    @(posedge clk);
    chk32(mem.addr[63:32], 32'h0123_4567);
    chk32(mem.addr[31:0], 32'h89ab_cdef);
    chk32({31'h0, mem.err}, 32'h0);
    $display("wide test done");
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, pmd_pkg::OFF_STATUS, 32'h0);
    chk32(r, pmd_pkg::STATUS_RESET);
    chkMode(pmd_pkg::STATUS_RESET);
    testTable();
    testUser();
    testWide();
    summarize();
  end
endmodule
